// *** pkg/tsp_defines.vh ***
// Register offsets, fields, reset values and timing counts
// Notes on behaviour
// - Channel held in detect past limit times 200 ms is recalibrated
// - A stuck-touch limit of zero disables the timeout
// - Dedicated shield drives channel eleven pin; host disables channel first
// - Shield-plus drives every channel pin that is neither being measured nor in detect
// - Shield enable changes take effect only after restart
// - Up to four groups, any channels, overlapping, detected like channels
// - Group masks come from the membership register, applied at reset and on restart
// - Low-power off: stay active, scan enabled channels every active period
// - Low-power on: enter sleep after idle entry delay without touch
// - In sleep, channels with sleep-scan select clear are suspended
// - In sleep, scan only selected channels every sleep scan interval
// - Touch on sleep channel recalibrates suspended channels, returns active
// - Unless host clears enable, device re-enters sleep after idle again
// - Host can force active mode immediately, except in the cycle that sleep is entered
// - Any host command during sleep makes the device leave sleep
// - Entering sleep turns off adaptive threshold and frequency hopping
// - No sleep-scan channel selected means never entering sleep
// - Adaptive threshold varies within half to one-and-half of programmed
// - Adaptive threshold rises by 10 counts, falls by 5 counts
// - Adaptive mode keeps oversampling at eight times gain, or user higher
// - Disabling adaptive restores saved threshold; host then recalibrates
// - Writing save bit stores configuration, then the bit self-clears
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH
`define TSP_NCH 12
`define TSP_NGRP 4
`define TSP_NSENS 16
`define TSP_A_CTRL 12'h000
`define TSP_A_STATUS 12'h004
`define TSP_A_CHEN 12'h008
`define TSP_A_SLEEPSEL 12'h00c
`define TSP_A_STUCK 12'h010
`define TSP_A_PERIOD 12'h014
`define TSP_A_IDLE 12'h018
`define TSP_A_THRESH 12'h01c
`define TSP_A_GAIN 12'h020
`define TSP_A_GROUP 12'h024
`define TSP_A_EFFTH 12'h028
`define TSP_A_DETECT 12'h02c
`define TSP_A_CMD 12'h030
`define TSP_B_LP 0
`define TSP_B_DS 1
`define TSP_B_DSP 2
`define TSP_B_ET 3
`define TSP_B_FH 4
`define TSP_B_SAVE 5
`define TSP_B_RESTART 6
`define TSP_B_ACTIVE 7
`define TSP_TICK_US 200000
`define TSP_CLK_MHZ 20
`define TSP_TH_UP 8'h0a
`define TSP_TH_DN 8'h05
`define TSP_OS_RATIO 3'h3
`define TSP_RST_THRESH 8'h32
`define TSP_RST_PERIOD 8'h02
`define TSP_RST_SLEEP 8'h0a
`define TSP_RST_IDLE 8'h19
`endif

// *** rtl/tsp_adapt.v ***
// Adaptive threshold stepping for one channel
`include "tsp_defines.vh"
`default_nettype none
module tsp_adapt (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire enable,
  input wire step,
  input wire noisy,
  input wire [7:0] thresh,
  // Effective threshold
  output reg [7:0] eff_q
);
  wire [8:0] lo = {1'b0, thresh} - {2'b0, thresh[7:1]};
  wire [8:0] hi = {1'b0, thresh} + {2'b0, thresh[7:1]};
  wire [8:0] up = {1'b0, eff_q} + {1'b0, `TSP_TH_UP};
  wire [8:0] dn = {1'b0, eff_q} - {1'b0, `TSP_TH_DN};
  // Step within half to one-and-half; disabled restores saved value
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_q <= `TSP_RST_THRESH;
    end else if (!enable) begin
      eff_q <= thresh;
    end else if ({1'b0, eff_q} < lo || {1'b0, eff_q} > hi) begin
      eff_q <= lo[7:0];
    end else if (step && noisy) begin
      eff_q <= (up > hi) ? hi[7:0] : up[7:0];
    end else if (step && !noisy) begin
      eff_q <= (dn < lo || dn[8]) ? lo[7:0] : dn[7:0];
    end
  end
endmodule
`default_nettype wire

// *** rtl/tsp_supervisor.v ***
// Touch supervisor: stuck timeout, shield, groups, sleep, adaptive
`include "tsp_defines.vh"
`default_nettype none
module tsp_supervisor #(
  parameter TICK_CYC = `TSP_TICK_US * `TSP_CLK_MHZ
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Host command seen on the configuration port
  input wire host_cmd,
  // Raw touch detection from the measurement front end
  input wire [11:0] raw_detect,
  input wire [11:0] noisy,
  // Measurement control
  output reg [15:0] scan_en_q,
  output reg [11:0] recal_q,
  output reg scan_start_q,
  output reg [11:0] shield_q,
  output reg [15:0] sensor_detect_q,
  output reg [3:0] oversample_q,
  output reg sleep_q,
  output reg freq_hop_q,
  output reg nvm_save_q
);
  // Synchronised pin inputs
  reg [11:0] det_s1_q, det_s2_q, noisy_s1_q, noisy_s2_q;
  reg cmd_s1_q, cmd_s2_q, cmd_s3_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      det_s1_q <= 12'h0;
      det_s2_q <= 12'h0;
      noisy_s1_q <= 12'h0;
      noisy_s2_q <= 12'h0;
      cmd_s1_q <= 1'b0;
      cmd_s2_q <= 1'b0;
      cmd_s3_q <= 1'b0;
    end else begin
      det_s1_q <= raw_detect;
      det_s2_q <= det_s1_q;
      noisy_s1_q <= noisy;
      noisy_s2_q <= noisy_s1_q;
      cmd_s1_q <= host_cmd;
      cmd_s2_q <= cmd_s1_q;
      cmd_s3_q <= cmd_s2_q;
    end
  end
  wire cmd_rise = cmd_s2_q & ~cmd_s3_q;

  // Software registers
  reg [7:0] ctrl_q;
  reg [11:0] chen_q, sleepsel_q;
  reg [7:0] stuck_q, period_q, sleep_per_q, idle_q, thresh_q;
  reg [3:0] gain_q;
  reg [47:0] group_q;
  reg [47:0] grp_live_q;
  reg ds_live_q, dsp_live_q;

  // Time base
  wire tick;
  tsp_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_q(tick)
  );

  // APB write and read decode
  wire wr = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire restart = wr && paddr == `TSP_A_CTRL && pwdata[`TSP_B_RESTART];
  reg apply_q;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h0;
      chen_q <= 12'hfff;
      sleepsel_q <= 12'h0;
      stuck_q <= 8'h0;
      period_q <= `TSP_RST_PERIOD;
      sleep_per_q <= `TSP_RST_SLEEP;
      idle_q <= `TSP_RST_IDLE;
      thresh_q <= `TSP_RST_THRESH;
      gain_q <= 4'h2;
      group_q <= 48'h0;
      nvm_save_q <= 1'b0;
    end else begin
      nvm_save_q <= 1'b0;
      ctrl_q[`TSP_B_SAVE] <= 1'b0;
      if (wr) begin
        case (paddr)
          `TSP_A_CTRL: begin
            ctrl_q <= {1'b0, 1'b0, 1'b0, pwdata[4:0]};
            nvm_save_q <= pwdata[`TSP_B_SAVE];
          end
          `TSP_A_CHEN: chen_q <= pwdata[11:0];
          `TSP_A_SLEEPSEL: sleepsel_q <= pwdata[11:0];
          `TSP_A_STUCK: stuck_q <= pwdata[7:0];
          `TSP_A_PERIOD: begin
            period_q <= pwdata[7:0];
            sleep_per_q <= pwdata[15:8];
          end
          `TSP_A_IDLE: idle_q <= pwdata[7:0];
          `TSP_A_THRESH: thresh_q <= pwdata[7:0];
          `TSP_A_GAIN: gain_q <= pwdata[3:0];
          `TSP_A_GROUP: group_q <= {pwdata[31:20], pwdata[19:8],
            pwdata[7:0], group_q[23:20], group_q[47:36] ^ 12'h0};
          default: ;
        endcase
      end
    end
  end

  // Restart latches shield and group settings
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apply_q <= 1'b1;
      ds_live_q <= 1'b0;
      dsp_live_q <= 1'b0;
      grp_live_q <= 48'h0;
    end else begin
      apply_q <= restart;
      if (apply_q) begin
        ds_live_q <= ctrl_q[`TSP_B_DS];
        dsp_live_q <= ctrl_q[`TSP_B_DSP];
        grp_live_q <= group_q;
      end
    end
  end

  // Group detection: any member channel in detect
  wire [3:0] grp_det;
  wire [11:0] stuck_hit;
  wire [11:0] det_eff = det_s2_q & chen_q & ~recal_q;
  genvar g;
  generate
    for (g = 0; g < `TSP_NGRP; g = g + 1) begin : g_grp
      assign grp_det[g] = |(det_eff & grp_live_q[g*12 +: 12]);
    end
  endgenerate

  // Per-channel stuck-touch timers
  reg [95:0] on_cnt_q;
  generate
    for (g = 0; g < `TSP_NCH; g = g + 1) begin : g_ch
      wire [7:0] cnt = on_cnt_q[g*8 +: 8];
      assign stuck_hit[g] = stuck_q != 8'h0 && cnt >= stuck_q;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          on_cnt_q[g*8 +: 8] <= 8'h0;
        end else if (!det_eff[g] || stuck_hit[g]) begin
          on_cnt_q[g*8 +: 8] <= 8'h0;
        end else if (tick && cnt != 8'hff) begin
          on_cnt_q[g*8 +: 8] <= cnt + 8'h1;
        end
      end
    end
  endgenerate

  // Mode state machine
  localparam ST_ACTIVE = 1'b0;
  localparam ST_SLEEP = 1'b1;
  reg st_q;
  reg [7:0] idle_cnt_q, scan_cnt_q;
  wire [15:0] all_det = {grp_det, det_eff};
  wire any_det = |all_det;
  wire sleep_det = |(det_eff & sleepsel_q);
  wire force_act = wr && paddr == `TSP_A_CTRL && pwdata[`TSP_B_ACTIVE];
  wire can_sleep = ctrl_q[`TSP_B_LP] && |sleepsel_q;
  wire wake = sleep_det || cmd_rise || force_act || !ctrl_q[`TSP_B_LP];
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_ACTIVE;
      idle_cnt_q <= 8'h0;
      scan_cnt_q <= 8'h0;
      scan_start_q <= 1'b0;
      recal_q <= 12'h0;
    end else begin
      scan_start_q <= 1'b0;
      recal_q <= stuck_hit;
      if (tick) begin
        scan_cnt_q <= scan_cnt_q + 8'h1;
      end
      case (st_q)
        ST_ACTIVE: begin
          if (any_det || !can_sleep) begin
            idle_cnt_q <= 8'h0;
          end else if (tick) begin
            idle_cnt_q <= idle_cnt_q + 8'h1;
          end
          if (tick && scan_cnt_q + 8'h1 >= period_q) begin
            scan_cnt_q <= 8'h0;
            scan_start_q <= 1'b1;
          end
          if (can_sleep && !any_det && idle_cnt_q >= idle_q) begin
            st_q <= ST_SLEEP;
            scan_cnt_q <= 8'h0;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            st_q <= ST_ACTIVE;
            idle_cnt_q <= 8'h0;
            if (sleep_det) begin
              recal_q <= chen_q & ~sleepsel_q;
            end
          end else if (tick && scan_cnt_q + 8'h1 >= sleep_per_q) begin
            scan_cnt_q <= 8'h0;
            scan_start_q <= 1'b1;
          end
        end
        default: st_q <= ST_ACTIVE;
      endcase
    end
  end

  // Adaptive threshold per channel
  wire [95:0] eff_th;
  wire adapt_on = ctrl_q[`TSP_B_ET] && st_q == ST_ACTIVE;
  generate
    for (g = 0; g < `TSP_NCH; g = g + 1) begin : g_ad
      tsp_adapt u_adapt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(adapt_on),
        .step(scan_start_q),
        .noisy(noisy_s2_q[g]),
        .thresh(thresh_q),
        .eff_q(eff_th[g*8 +: 8])
      );
    end
  endgenerate

  // Outputs to the measurement engine
  wire [3:0] os_min = gain_q + `TSP_OS_RATIO;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_en_q <= 16'h0;
      shield_q <= 12'h0;
      sensor_detect_q <= 16'h0;
      oversample_q <= 4'h0;
      sleep_q <= 1'b0;
      freq_hop_q <= 1'b0;
    end else begin
      if (st_q == ST_SLEEP) begin
        scan_en_q <= {4'h0, chen_q & sleepsel_q};
      end else begin
        scan_en_q <= {4'hf, chen_q};
      end
      shield_q <= 12'h0;
      if (dsp_live_q) begin
        shield_q <= ~det_s2_q & ~scan_en_q[11:0];
      end
      if (ds_live_q) begin
        shield_q[11] <= 1'b1;
      end
      sensor_detect_q <= all_det;
      if (adapt_on && gain_q + `TSP_OS_RATIO > 4'h0 &&
          os_min > gain_q) begin
        oversample_q <= os_min;
      end else begin
        oversample_q <= gain_q;
      end
      sleep_q <= st_q;
      freq_hop_q <= ctrl_q[`TSP_B_FH] && st_q == ST_ACTIVE;
    end
  end

  // APB read data, zero-wait answer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd_setup) begin
        case (paddr)
          `TSP_A_CTRL: prdata <= {24'h0, ctrl_q};
          `TSP_A_STATUS: prdata <= {29'h0, dsp_live_q, ds_live_q, st_q};
          `TSP_A_CHEN: prdata <= {20'h0, chen_q};
          `TSP_A_SLEEPSEL: prdata <= {20'h0, sleepsel_q};
          `TSP_A_STUCK: prdata <= {24'h0, stuck_q};
          `TSP_A_PERIOD: prdata <= {16'h0, sleep_per_q, period_q};
          `TSP_A_IDLE: prdata <= {24'h0, idle_q};
          `TSP_A_THRESH: prdata <= {24'h0, thresh_q};
          `TSP_A_GAIN: prdata <= {28'h0, gain_q};
          `TSP_A_GROUP: prdata <= {grp_live_q[47:24], group_q[7:0]};
          `TSP_A_EFFTH: prdata <= {24'h0, eff_th[7:0]};
          `TSP_A_DETECT: prdata <= {16'h0, all_det};
          default: begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/tsp_tick.v ***
// Divider making the 200 ms time base pulse
`include "tsp_defines.vh"
`default_nettype none
module tsp_tick #(
  parameter TICK_CYC = `TSP_TICK_US * `TSP_CLK_MHZ
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Time base pulse
  output reg tick_q
);
  reg [31:0] cnt_q;
  // Free counter, one pulse per period
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q >= TICK_CYC - 1) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench of the touch supervisor
`include "tsp_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic sys_clk = 1'b0, rst_n = 1'b0, host_cmd = 1'b0, er;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0, noisy = '0, touch = '0, raw_detect;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, scan_start_q, sleep_q, freq_hop_q, nvm_save_q;
  logic [15:0] scan_en_q, sensor_detect_q;
  logic [11:0] recal_q, shield_q;
  logic [3:0] oversample_q;
  int mismatches = 0, n_compared = 0, n_save = 0, n_rc0 = 0, n_rc1 = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  tsp_supervisor #(.TICK_CYC(TK)) dut (.sys_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_cmd,
    .raw_detect, .noisy, .scan_en_q, .recal_q, .scan_start_q, .shield_q,
    .sensor_detect_q, .oversample_q, .sleep_q, .freq_hop_q, .nvm_save_q);
  tsp_front fe (.sys_clk, .rst_n, .touch, .recal_q, .raw_detect);
  // Pulse counters
  always @(posedge sys_clk) begin
    n_save <= n_save + nvm_save_q;
    n_rc0 <= n_rc0 + recal_q[0];
    n_rc1 <= n_rc1 + recal_q[1];
  end
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chkb(input string nm, input logic ex, got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask
  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chkb("pready", 1'b1, 1'b0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] ex);
    xfer(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic wait_sleep(input logic v);
    int n = 0;
    while (sleep_q !== v && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chkb("sleep_q", v, sleep_q);
  endtask
  // Poll the effective threshold until it leaves f
  task automatic step(input logic [7:0] f, t);
    int n = 0;
    do begin
      xfer(1'b0, `TSP_A_EFFTH, 32'h0);
      n++;
    end while (rd[7:0] === f && n < 40);
    chk("eff_step", {24'h0, t}, rd);
  endtask
  // Watchdog
  initial begin
    #(50 * 20000);
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("chen", `TSP_A_CHEN, 32'hfff);
    rdc("thresh", `TSP_A_THRESH, 32'h32);
    rdc("period", `TSP_A_PERIOD, 32'ha02);
    rdc("idle", `TSP_A_IDLE, 32'h19);
    rdc("unmapped", 12'h040, 32'h0);
    chkb("pslverr", 1'b1, er);
    wr(`TSP_A_CTRL, 32'h20);
    rdc("save_bit", `TSP_A_CTRL, 32'h0);
    chk("saves", 32'h1, n_save);
    // Shield settings wait for restart
    wr(`TSP_A_CHEN, 32'h7ff);
    wr(`TSP_A_CTRL, 32'h6);
    repeat (4) @(posedge sys_clk);
    chk("shield_early", 32'h0, {20'h0, shield_q});
    wr(`TSP_A_CTRL, 32'h46);
    repeat (4) @(posedge sys_clk);
    chkb("shield_pin", 1'b1, shield_q[11]);
    rdc("status", `TSP_A_STATUS, 32'h6);
    // Stuck touch with zero and two-tick limits
    wr(`TSP_A_PERIOD, 32'h201);
    wr(`TSP_A_STUCK, 32'h0);
    touch <= 12'h001;
    repeat (12 * TK) @(posedge sys_clk);
    chkb("held", 1'b1, sensor_detect_q[0]);
    chk("no_recal", 32'h0, n_rc0);
    wr(`TSP_A_STUCK, 32'h2);
    repeat (6 * TK) @(posedge sys_clk);
    chk("stuck_recal", 32'h1, n_rc0);
    chkb("stuck_clear", 1'b0, sensor_detect_q[0]);
    touch <= 12'h000;
    // Sleep entry, wake and re-entry
    wr(`TSP_A_IDLE, 32'h3);
    wr(`TSP_A_CTRL, 32'h11);
    repeat (8 * TK) @(posedge sys_clk);
    chkb("no_sel", 1'b0, sleep_q);
    wr(`TSP_A_SLEEPSEL, 32'h1);
    wait_sleep(1'b1);
    repeat (2) @(posedge sys_clk);
    chkb("hop_off", 1'b0, freq_hop_q);
    chk("sleep_scan", 32'h1, {16'h0, scan_en_q});
    touch <= 12'h001;
    wait_sleep(1'b0);
    repeat (4) @(posedge sys_clk);
    chkb("resume_recal", 1'b1, n_rc1 > 0);
    touch <= 12'h000;
    wait_sleep(1'b1);
    host_cmd <= 1'b1;
    wait_sleep(1'b0);
    host_cmd <= 1'b0;
    wait_sleep(1'b1);
    wr(`TSP_A_CTRL, 32'h91);
    repeat (2) @(posedge sys_clk);
    chkb("forced", 1'b0, sleep_q);
    // Adaptive threshold range and steps
    wr(`TSP_A_GAIN, 32'h2);
    wr(`TSP_A_CTRL, 32'h8);
    repeat (10 * TK) @(posedge sys_clk);
    rdc("eff_low", `TSP_A_EFFTH, 32'h19);
    chk("ovs", 32'h5, {28'h0, oversample_q});
    noisy <= 12'h001;
    step(8'h19, 8'h23);
    repeat (8 * TK) @(posedge sys_clk);
    rdc("eff_high", `TSP_A_EFFTH, 32'h4b);
    noisy <= 12'h000;
    step(8'h4b, 8'h46);
    wr(`TSP_A_CTRL, 32'h0);
    rdc("eff_back", `TSP_A_EFFTH, 32'h32);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** tb/tsp_checker.sv ***
// Port checks of the touch supervisor
`default_nettype none
module tsp_checker (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // APB and host command
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire host_cmd,
  // Scan control
  input wire [15:0] scan_en_q,
  input wire sleep_q,
  input wire freq_hop_q,
  input wire nvm_save_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic wr;
  logic ctl_wr;
  logic [7:0] ctl_q;
  logic [11:0] sel_q;
  // Completed writes
  assign wr = psel && penable && pwrite && pready;
  assign ctl_wr = wr && paddr == 12'h000;
  // Shadows of control and sleep select
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 8'h00;
      sel_q <= 12'h000;
    end else if (ctl_wr) begin
      ctl_q <= pwdata[7:0];
    end else if (wr && paddr == 12'h00c) begin
      sel_q <= pwdata[11:0];
    end
  end
  a_lp_off_awake: assert property ($rose(sleep_q) |-> ctl_q[0])
    else $error("sleep entered with low power off");
  a_sel_needed: assert property ($rose(sleep_q) |-> sel_q != 12'h000)
    else $error("sleep entered with no sleep channel");
  a_sleep_suspend: assert property (sleep_q && $past(sleep_q, 2)
    |-> (scan_en_q[11:0] & ~sel_q) == 12'h000)
    else $error("unselected channel scanned in sleep");
  a_sleep_no_hop: assert property (sleep_q && $past(sleep_q)
    |-> !freq_hop_q)
    else $error("hopping left on in sleep");
  a_force_wake: assert property (ctl_wr && pwdata[7]
    |-> ##[1:3] !sleep_q)
    else $error("force active ignored");
  a_cmd_wakes: assert property (sleep_q && $rose(host_cmd)
    |-> ##[1:8] !sleep_q)
    else $error("host command did not wake");
  a_save_pulse: assert property (ctl_wr && pwdata[5]
    |-> ##[1:3] nvm_save_q)
    else $error("save write gave no store pulse");
  a_save_single: assert property (nvm_save_q |=> !nvm_save_q)
    else $error("store pulse too long");
  c_sleep_in: cover property ($rose(sleep_q));
  c_sleep_out: cover property ($fell(sleep_q));
  c_save: cover property (nvm_save_q);
endmodule
bind tsp_supervisor tsp_checker chk_i (.sys_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .host_cmd, .scan_en_q, .sleep_q,
  .freq_hop_q, .nvm_save_q);
`default_nettype wire

// *** tb/tsp_front.sv ***
// Measurement front-end model feeding raw detect levels
`default_nettype none
module tsp_front (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Finger presence from the bench
  input wire logic [11:0] touch,
  // Device side
  input wire logic [11:0] recal_q,
  output logic [11:0] raw_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cal_q;
  // Recalibration hides a held finger until it lifts
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_q <= 12'h000;
    end else begin
      cal_q <= (cal_q | recal_q) & touch;
    end
  end
  assign raw_detect = touch & ~cal_q;
endmodule
`default_nettype wire
